/* File: rtl/fscr_map.svh */
// Bit positions, masks, reset values, opcodes and timing of the register block
`ifndef FSCR_MAP_SVH
`define FSCR_MAP_SVH
// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define FSCR_ST_WIP     0
`define FSCR_ST_WEL     1
`define FSCR_ST_BP_LO   2
`define FSCR_ST_BP_HI   5
`define FSCR_CF_DS_HI   2
`define FSCR_CF_TB      3
`define FSCR_CF_PBE     4
`define FSCR_BP_RST     4'h0
`define FSCR_DS_RST     3'h7
`define FSCR_ADDR_ST    32'h00000000
`define FSCR_ADDR_CF    32'h00000001
// ----------------------------------------------------------------------------
// Opcodes (second byte is the complement)
// ----------------------------------------------------------------------------
`define FSCR_OP_WRREG   8'h01
`define FSCR_OP_RDST    8'h05
`define FSCR_OP_RDCF    8'h15
`define FSCR_OP_WRITE_LATCH_SET_CMD    8'h06
`define FSCR_OP_PP      8'h12
`define FSCR_OP_SE      8'h21
`define FSCR_OP_BE      8'hDC
`define FSCR_OP_CE      8'h60
// ----------------------------------------------------------------------------
// Link and timing
// ----------------------------------------------------------------------------
`define FSCR_DUMMY      3'h4
`define FSCR_PREAMBLE   8'h5A
`define FSCR_CLK_NS     4
`define FSCR_NVW_NS     40
`define FSCR_NVW_CYC    ((`FSCR_NVW_NS + `FSCR_CLK_NS - 1) / `FSCR_CLK_NS)
`endif

/* File: rtl/fscr_pkg.sv */
// Types shared by the register block modules
package fscr_pkg;
    // Command sequencer states
    typedef enum logic [6:0] {
        S_IDLE    = 7'h01,
        S_CPL     = 7'h02,
        S_ADDR    = 7'h04,
        S_DUMMY   = 7'h08,
        S_DATA_RD = 7'h10,
        S_DATA_WR = 7'h20,
        S_SKIP    = 7'h40
    } fscr_state_t;
    // Array operation kinds handed to the array engine
    typedef enum logic [1:0] {
        OP_PROG = 2'h0,
        OP_SECT = 2'h1,
        OP_BLK  = 2'h2,
        OP_CHIP = 2'h3
    } fscr_op_t;
endpackage

/* File: rtl/fscr_link_if.sv */
// Synchronised link events passed from the receiver to the sequencer
interface fscr_link_if;
    logic       frame;
    logic       frame_start;
    logic       frame_end;
    logic       rise;
    logic       fall;
    logic [7:0] rx_byte;
    modport rx   (output frame, frame_start, frame_end, rise, fall, rx_byte);
    modport core (input  frame, frame_start, frame_end, rise, fall, rx_byte);
endinterface

/* File: rtl/fscr_link_rx.sv */
// Link pin synchroniser and edge finder
module fscr_link_rx (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Link pins
    input  wire logic       i_link_clk,
    input  wire logic       i_cs_n,
    input  wire logic [7:0] i_dq,
    // Events
    fscr_link_if.rx         lnk
);
    // ------------------------------------------------------------------------
    // Two-stage synchronisers plus one history stage
    // ------------------------------------------------------------------------
    logic [9:0] s1_q;
    logic [9:0] s2_q;
    logic [1:0] s3_q;

    // Stage one feeds stage two only
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            s1_q <= 10'h200;
            s2_q <= 10'h200;
            s3_q <= 2'h2;
        end else begin
            s1_q <= {i_cs_n, i_link_clk, i_dq};
            s2_q <= s1_q;
            s3_q <= s2_q[9:8];
        end
    end

    // Edges of chip select and link clock
    assign lnk.frame       = ~s2_q[9];
    assign lnk.frame_start = ~s2_q[9] & s3_q[1];
    assign lnk.frame_end   = s2_q[9] & ~s3_q[1];
    assign lnk.rise        = ~s2_q[9] & s2_q[8] & ~s3_q[0];
    assign lnk.fall        = ~s2_q[9] & ~s2_q[8] & s3_q[0];
    assign lnk.rx_byte     = s2_q[7:0];
endmodule

/* File: rtl/fscr_regs.sv */
// Status and configuration register storage
`include "fscr_map.svh"
module fscr_regs (
    // Clock and reset
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    // Latch control and busy
    input  wire logic       i_wel_set,
    input  wire logic       i_wel_clr,
    input  wire logic       i_wip,
    // Register write commit
    input  wire logic       i_commit,
    input  wire logic       i_sel_cfg,
    input  wire logic [7:0] i_wdata,
    // Register view
    output logic      [7:0] o_status,
    output logic      [7:0] o_config
);
    logic       wel_q;
    logic [3:0] bp_q;
    logic       tb_q;
    logic       pbe_q;
    logic [2:0] ds_q;

    // ------------------------------------------------------------------------
    // Write enable latch: a set beats a clear in the same cycle
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wel_q <= 1'b0;
        end else if (i_wel_set) begin
            wel_q <= 1'b1;
        end else if (i_wel_clr) begin
            wel_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Field update, only on a completed register write
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            bp_q  <= `FSCR_BP_RST;
            tb_q  <= 1'b0;
            pbe_q <= 1'b0;
            ds_q  <= `FSCR_DS_RST;
        end else if (i_commit && !i_sel_cfg) begin
            bp_q  <= i_wdata[`FSCR_ST_BP_HI:`FSCR_ST_BP_LO];
        end else if (i_commit) begin
            tb_q  <= tb_q | i_wdata[`FSCR_CF_TB];
            pbe_q <= i_wdata[`FSCR_CF_PBE];
            ds_q  <= i_wdata[`FSCR_CF_DS_HI:0];
        end
    end

    // Reserved bits read as zero
    assign o_status = {2'h0, bp_q, wel_q, i_wip};
    assign o_config = {3'h0, pbe_q, tb_q, ds_q};
endmodule

/* File: rtl/fscr_top.sv */
// Command sequencer, protection gate and pin driver of the register block
`include "fscr_map.svh"
// Function
// - Busy flag bit 0 high during write cycles
// - Latch-set command sets write enable bit 1
// - Program or erase without latch is dropped
// - Latch clears when program or erase finishes
// - Protected target: refuse, clear write enable latch
// - Protect level held in status bits 5..2
// - Protected program/erase refused; level via write only
// - Whole array wipe only at level zero
// - Protect level resets to zero
// - Top/bottom bit anchors the protected area
// - Top/bottom bit is one-time programmable
// - Preamble pattern on dummy cycles when enabled
// - Drive strength three bits, default all ones
// - Configuration fields change only by register write
// - Write: opcode, complement, four address, one data
// - Register reads use exactly four dummy cycles
module fscr_top (
    // Clock and reset
    input  wire logic                i_mclk,
    input  wire logic                i_rst,
    // Link pins
    input  wire logic                i_link_clk,
    input  wire logic                i_cs_n,
    input  wire logic [7:0]          i_dq,
    output logic      [7:0]          o_dq,
    output logic                     o_dq_oe,
    // Array engine
    output logic                     o_op_start,
    output fscr_pkg::fscr_op_t       o_op_kind,
    output logic      [31:0]         o_op_addr,
    input  wire logic                i_op_done,
    input  wire logic                i_addr_protected,
    // Register view
    output logic      [7:0]          o_status,
    output logic      [7:0]          o_config,
    output logic      [3:0]          o_bp_level,
    output logic                     o_top_bottom,
    output logic      [2:0]          o_drive_code
);
    import fscr_pkg::*;

    fscr_link_if lnk ();

    fscr_state_t state_q;
    fscr_state_t state_d;
    fscr_op_t    kind_q;
    fscr_op_t    kind_w;
    logic [7:0]  opc_q;
    logic [31:0] addr_q;
    logic [7:0]  wdata_q;
    logic [2:0]  cnt_q;
    logic [2:0]  cnt_d;
    logic        done_q;
    logic        done_d;
    logic        arr_busy_q;
    logic        start_q;
    logic [3:0]  nvw_cnt_q;
    logic        cmt_cfg_q;
    logic [7:0]  cmt_data_q;
    logic [7:0]  dq_q;
    logic        oe_q;

    // ------------------------------------------------------------------------
    // Opcode decoding
    // ------------------------------------------------------------------------
    function automatic logic is_pe(input logic [7:0] op);
        return op == `FSCR_OP_PP || op == `FSCR_OP_SE || op == `FSCR_OP_BE
            || op == `FSCR_OP_CE;
    endfunction

    function automatic logic is_rd(input logic [7:0] op);
        return op == `FSCR_OP_RDST || op == `FSCR_OP_RDCF;
    endfunction

    function automatic logic has_addr(input logic [7:0] op);
        return is_rd(op) || op == `FSCR_OP_WRREG || (is_pe(op) && op != `FSCR_OP_CE);
    endfunction

    // ------------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------------
    logic write_in_progress;
    logic write_enable_latch;
    logic exec;
    logic write_latch_set_cmd_go;
    logic nvw_go;
    logic pe_go;
    logic prot;
    logic arr_done;
    logic nv_commit;
    logic wel_clr;
    logic cpl_ok;
    logic [7:0] rd_byte;

    fscr_link_rx u_rx (
        .i_mclk     (i_mclk),
        .i_rst      (i_rst),
        .i_link_clk (i_link_clk),
        .i_cs_n     (i_cs_n),
        .i_dq       (i_dq),
        .lnk        (lnk)
    );

    fscr_regs u_regs (
        .i_mclk    (i_mclk),
        .i_rst     (i_rst),
        .i_wel_set (write_latch_set_cmd_go),
        .i_wel_clr (wel_clr),
        .i_wip     (write_in_progress),
        .i_commit  (nv_commit),
        .i_sel_cfg (cmt_cfg_q),
        .i_wdata   (cmt_data_q),
        .o_status  (o_status),
        .o_config  (o_config)
    );

    // ------------------------------------------------------------------------
    // Execution decisions at frame end
    // ------------------------------------------------------------------------
    assign write_enable_latch       = o_status[`FSCR_ST_WEL];
    assign write_in_progress       = arr_busy_q | (nvw_cnt_q != 4'h0);
    assign exec      = lnk.frame_end & done_q;
    assign write_latch_set_cmd_go   = exec & (opc_q == `FSCR_OP_WRITE_LATCH_SET_CMD) & ~write_in_progress;
    assign nvw_go    = exec & (opc_q == `FSCR_OP_WRREG) & ~write_in_progress & write_enable_latch
                     & (addr_q == `FSCR_ADDR_ST || addr_q == `FSCR_ADDR_CF);
    assign pe_go     = exec & is_pe(opc_q) & ~write_in_progress & write_enable_latch;
    assign prot      = (opc_q == `FSCR_OP_CE) ? (o_bp_level != 4'h0)
                                               : i_addr_protected;
    assign arr_done  = arr_busy_q & i_op_done;
    assign nv_commit = nvw_cnt_q == 4'h1;
    assign wel_clr   = arr_done | (pe_go & prot) | nv_commit;
    assign cpl_ok    = lnk.rx_byte == ~opc_q;
    assign kind_w    = (opc_q == `FSCR_OP_PP) ? OP_PROG :
                       (opc_q == `FSCR_OP_SE) ? OP_SECT :
                       (opc_q == `FSCR_OP_BE) ? OP_BLK  : OP_CHIP;
    assign rd_byte   = (opc_q == `FSCR_OP_RDCF) ? o_config : o_status;

    // Outputs from flops and register fields
    assign o_op_start   = start_q;
    assign o_op_kind    = kind_q;
    assign o_op_addr    = addr_q;
    assign o_dq         = dq_q;
    assign o_dq_oe      = oe_q;
    assign o_bp_level   = o_status[`FSCR_ST_BP_HI:`FSCR_ST_BP_LO];
    assign o_top_bottom = o_config[`FSCR_CF_TB];
    assign o_drive_code = o_config[`FSCR_CF_DS_HI:0];

    // ------------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------------
    // Next state on each link rising edge
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        done_d  = done_q;
        if (lnk.frame_start) begin
            state_d = S_IDLE;
            cnt_d   = 3'h0;
            done_d  = 1'b0;
        end else if (lnk.rise) begin
            case (state_q)
                S_IDLE: begin
                    state_d = S_CPL;
                end
                S_CPL: begin
                    state_d = (cpl_ok && has_addr(opc_q)) ? S_ADDR : S_SKIP;
                    done_d  = cpl_ok && !has_addr(opc_q);
                end
                S_ADDR: begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == 3'h3) begin
                        cnt_d = 3'h0;
                        if (is_rd(opc_q)) begin
                            state_d = S_DUMMY;
                        end else if (opc_q == `FSCR_OP_WRREG) begin
                            state_d = S_DATA_WR;
                        end else begin
                            state_d = S_SKIP;
                            done_d  = 1'b1;
                        end
                    end
                end
                S_DUMMY: begin
                    cnt_d = cnt_q + 3'h1;
                    if (cnt_q == `FSCR_DUMMY - 3'h1) begin
                        state_d = S_DATA_RD;
                    end
                end
                S_DATA_WR: begin
                    state_d = S_SKIP;
                    done_d  = 1'b1;
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    // Sequencer state
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_q <= S_IDLE;
            cnt_q   <= 3'h0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            done_q  <= done_d;
        end
    end

    // Opcode, address and data capture
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            opc_q   <= 8'h00;
            addr_q  <= 32'h00000000;
            wdata_q <= 8'h00;
        end else if (lnk.rise && state_q == S_IDLE) begin
            opc_q   <= lnk.rx_byte;
        end else if (lnk.rise && state_q == S_ADDR) begin
            addr_q  <= {addr_q[23:0], lnk.rx_byte};
        end else if (lnk.rise && state_q == S_DATA_WR) begin
            wdata_q <= lnk.rx_byte;
        end
    end

    // ------------------------------------------------------------------------
    // Array operation launch and busy tracking
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            arr_busy_q <= 1'b0;
            start_q    <= 1'b0;
            kind_q     <= OP_PROG;
        end else begin
            start_q <= pe_go & ~prot;
            if (pe_go && !prot) begin
                arr_busy_q <= 1'b1;
                kind_q     <= kind_w;
            end else if (arr_done) begin
                arr_busy_q <= 1'b0;
            end
        end
    end

    // Register write cycle timer; reserved data bits are dropped at commit
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            nvw_cnt_q  <= 4'h0;
            cmt_cfg_q  <= 1'b0;
            cmt_data_q <= 8'h00;
        end else if (nvw_go) begin
            nvw_cnt_q  <= 4'(`FSCR_NVW_CYC);
            cmt_cfg_q  <= addr_q[0];
            cmt_data_q <= wdata_q;
        end else if (nvw_cnt_q != 4'h0) begin
            nvw_cnt_q  <= nvw_cnt_q - 4'h1;
        end
    end

    // ------------------------------------------------------------------------
    // Output pins, launched on link falling edges
    // ------------------------------------------------------------------------
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            dq_q <= 8'h00;
            oe_q <= 1'b0;
        end else if (!lnk.frame) begin
            oe_q <= 1'b0;
        end else if (lnk.fall && state_q == S_DUMMY) begin
            dq_q <= `FSCR_PREAMBLE;
            oe_q <= o_config[`FSCR_CF_PBE];
        end else if (lnk.fall && state_q == S_DATA_RD) begin
            dq_q <= rd_byte;
            oe_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    property p_wip_on_start;
        arr_busy_q && !arr_done |=> o_status[0];
    endproperty
    a_wip_on_start: assert property (p_wip_on_start) else $error("busy low in op");

    property p_wel_set;
        write_latch_set_cmd_go |=> write_enable_latch;
    endproperty
    a_wel_set: assert property (p_wel_set) else $error("latch not set");

    property p_start_gated;
        o_op_start |-> $past(write_enable_latch);
    endproperty
    a_start_gated: assert property (p_start_gated) else $error("op without latch");

    property p_wel_done;
        arr_done && !write_latch_set_cmd_go |=> !write_enable_latch && !o_status[0];
    endproperty
    a_wel_done: assert property (p_wel_done) else $error("latch kept after op");

    property p_prot_refuse;
        pe_go && prot |=> !o_op_start && !write_enable_latch;
    endproperty
    a_prot_refuse: assert property (p_prot_refuse) else $error("protected op run");

    property p_chip_level;
        o_op_start && o_op_kind == OP_CHIP |-> o_bp_level == 4'h0;
    endproperty
    a_chip_level: assert property (p_chip_level) else $error("chip wipe while locked");

    property p_tb_sticky;
        o_top_bottom |=> o_top_bottom;
    endproperty
    a_tb_sticky: assert property (p_tb_sticky) else $error("top/bottom reverted");

    property p_write_only;
        !nv_commit |=> $stable(o_config) && $stable(o_bp_level);
    endproperty
    a_write_only: assert property (p_write_only) else $error("field changed");

    property p_preamble;
        lnk.fall && lnk.frame && state_q == S_DUMMY |=> o_dq_oe == o_config[4];
    endproperty
    a_preamble: assert property (p_preamble) else $error("preamble drive wrong");

    property p_dummy_count;
        lnk.rise && state_q == S_ADDR && cnt_q == 3'h3 && is_rd(opc_q)
            |=> state_q == S_DUMMY && cnt_q == 3'h0;
    endproperty
    a_dummy_count: assert property (p_dummy_count) else $error("dummy start wrong");

    property p_reserved;
        o_status[7:6] == 2'h0 && o_config[7:5] == 3'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_nvw_cycle;
        nvw_go |=> o_status[0] [*8] ##2 nv_commit ##1 !write_enable_latch;
    endproperty
    a_nvw_cycle: assert property (p_nvw_cycle) else $error("write cycle wrong");
endmodule

/* File: sim/fscr_host_model.sv */
// Host controller model that drives octal link frames into the register block
module fscr_host_model (
    // Clock
    input  wire logic       i_mclk,
    // Device answer
    input  wire logic [7:0] i_dq,
    input  wire logic       i_dq_oe,
    // Link pins
    output logic            o_link_clk,
    output logic            o_cs_n,
    output logic [7:0]      o_dq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rd_dq[$];
    logic       rd_oe[$];
    // ------------------------------------------------------------------
    // Idle pins: link clock stands low outside frames
    // ------------------------------------------------------------------
    initial begin
        o_link_clk = 1'b0;
        o_cs_n     = 1'b1;
        o_dq       = 8'hA5;
    end
    // Half of one 32 ns link period
    task automatic half();
        repeat (4) @(negedge i_mclk);
    endtask
    // One frame: opcode, complement, address MSB first, data, then read cycles
    task automatic frame(input logic [7:0] q[$], input int n_rd);
        rd_dq.delete();
        rd_oe.delete();
        o_cs_n = 1'b0;
        foreach (q[i]) begin
            o_dq = q[i];
            half();
            o_link_clk = 1'b1;
            half();
            o_link_clk = 1'b0;
        end
        // Dummy cycles then data; a released bus reads back as the inverse
        repeat (n_rd) begin
            o_dq = ~o_dq;
            half();
            o_link_clk = 1'b1;
            repeat (3) @(negedge i_mclk);
            rd_dq.push_back(i_dq_oe ? i_dq : ~i_dq);
            rd_oe.push_back(i_dq_oe);
            @(negedge i_mclk);
            o_link_clk = 1'b0;
        end
        half();
        o_cs_n = 1'b1;
        o_dq   = ~o_dq;
        half();
    endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench of the status and configuration register block
`include "fscr_map.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (a), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import fscr_pkg::*;
    logic        mclk, rst, lclk, cs_n, prot, done;
    logic [7:0]  dq_in, dq_out, status, config_v;
    logic        dq_oe, op_start, top_bot;
    fscr_op_t    op_kind, kind_s;
    logic [31:0] op_addr, addr_s;
    logic [3:0]  bp;
    logic [2:0]  drv;
    logic [4:0]  done_cnt;
    int          err_total, num_checks, n_start, wip_cyc;
    // ------------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    fscr_top u_dut (.i_mclk(mclk), .i_rst(rst), .i_link_clk(lclk), .i_cs_n(cs_n),
        .i_dq(dq_in), .o_dq(dq_out), .o_dq_oe(dq_oe), .o_op_start(op_start),
        .o_op_kind(op_kind), .o_op_addr(op_addr), .i_op_done(done),
        .i_addr_protected(prot), .o_status(status), .o_config(config_v),
        .o_bp_level(bp), .o_top_bottom(top_bot), .o_drive_code(drv));
    fscr_host_model u_host (.i_mclk(mclk), .i_dq(dq_out), .i_dq_oe(dq_oe),
        .o_link_clk(lclk), .o_cs_n(cs_n), .o_dq(dq_in));
    // Array engine: records launches, answers done 20 cycles later
    always @(negedge mclk) begin
        done <= (done_cnt == 5'h01);
        if (status[0] === 1'b1) wip_cyc++;
        if (op_start === 1'b1) begin
            n_start++;
            kind_s = op_kind;
            addr_s = op_addr;
            done_cnt <= 5'h14;
        end else if (done_cnt != 5'h00) done_cnt <= done_cnt - 5'h01;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Builds and sends one frame
    task automatic cmd(input logic [7:0] op, input int na, input logic [31:0] a,
                       input int nd, input logic [7:0] d, input int nrd);
        logic [7:0] q[$];
        q = {op, ~op};
        for (int i = na - 1; i >= 0; i--) q.push_back(a[8*i +: 8]);
        if (nd != 0) q.push_back(d);
        u_host.frame(q, nrd);
    endtask
    // Polls status over the link until busy clears, then judges the latch
    task automatic wait_idle(input logic write_enable_latch);
        for (int n = 0; n < 20; n++) begin
            cmd(`FSCR_OP_RDST, 4, 32'h0, 0, 8'h00, 6);
            if (u_host.rd_dq[4][0] === 1'b0) begin
                `CHK(u_host.rd_dq[5][1], write_enable_latch)
                return;
            end
        end
        err_total++;
        give_verdict();
    endtask
    // Latch set, then register write to status (0) or config (1)
    task automatic wrreg(input logic sel, input logic [7:0] d);
        cmd(`FSCR_OP_WRITE_LATCH_SET_CMD, 0, 32'h0, 0, 8'h00, 0);
        wip_cyc = 0;
        cmd(`FSCR_OP_WRREG, 4, {31'h0, sel}, 1, d, 0);
        wait_idle(1'b0);
        `CHK(wip_cyc, 10)
    endtask
    // Register read: dummy cycles carry preamble only when enabled
    task automatic t_read(input logic [7:0] op, input logic [7:0] exp, input logic preamble_enable);
        cmd(op, 4, {31'h0, op == `FSCR_OP_RDCF}, 0, 8'h00, 6);
        for (int i = 0; i < 4; i++) begin
            `CHK(u_host.rd_oe[i], preamble_enable)
            if (preamble_enable) `CHK(u_host.rd_dq[i], `FSCR_PREAMBLE)
        end
        `CHK(u_host.rd_oe[4], 1'b1)
        `CHK(u_host.rd_dq[4], exp)
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_no_latch();
        cmd(`FSCR_OP_PP, 4, 32'h100, 1, 8'hAA, 0);
        cmd(`FSCR_OP_CE, 0, 32'h0, 0, 8'h00, 0);
        `CHK(n_start, 0)
        `CHK(status, 8'h00)
    endtask
    task automatic t_config();
        wrreg(1'b1, 8'hFF);
        `CHK(config_v, 8'h1F)
        wrreg(1'b1, 8'h10);
        `CHK(config_v, 8'h18)
        `CHK(top_bot, 1'b1)
        `CHK(drv, 3'h0)
        t_read(`FSCR_OP_RDCF, 8'h18, 1'b1);
        cmd(`FSCR_OP_WRITE_LATCH_SET_CMD, 0, 32'h0, 0, 8'h00, 0);
        `CHK(status, 8'h02)
        `CHK(config_v, 8'h18)
        // Register write to an address other than status or config is dropped
        cmd(`FSCR_OP_WRREG, 4, 32'h2, 1, 8'h00, 0);
        `CHK(config_v, 8'h18)
        `CHK(status, 8'h02)
    endtask
    task automatic t_ops();
        logic [7:0] ops[3];
        ops = '{`FSCR_OP_PP, `FSCR_OP_SE, `FSCR_OP_BE};
        for (int k = 0; k < 3; k++) begin
            if (k != 0) cmd(`FSCR_OP_WRITE_LATCH_SET_CMD, 0, 32'h0, 0, 8'h00, 0);
            wip_cyc = 0;
            cmd(ops[k], 4, 32'h0123_4500 + k, (k == 0) ? 1 : 0, 8'h3C, 0);
            wait_idle(1'b0);
            `CHK(n_start, k + 1)
            `CHK(kind_s, fscr_op_t'(k))
            `CHK(addr_s, 32'h0123_4500 + k)
            `CHK(wip_cyc > 20, 1'b1)
        end
    endtask
    task automatic t_protect();
        wrreg(1'b0, 8'h0C);
        `CHK(bp, 4'h3)
        prot = 1'b1;
        cmd(`FSCR_OP_WRITE_LATCH_SET_CMD, 0, 32'h0, 0, 8'h00, 0);
        cmd(`FSCR_OP_SE, 4, 32'h0000_1000, 0, 8'h00, 0);
        wait_idle(1'b0);
        `CHK(n_start, 3)
        prot = 1'b0;
        cmd(`FSCR_OP_WRITE_LATCH_SET_CMD, 0, 32'h0, 0, 8'h00, 0);
        cmd(`FSCR_OP_CE, 0, 32'h0, 0, 8'h00, 0);
        // Level 3 kept, latch cleared by the refused wipe, not busy
        t_read(`FSCR_OP_RDST, 8'h0C, 1'b1);
        `CHK(n_start, 3)
        wrreg(1'b0, 8'hC0);
        `CHK(status, 8'h00)
        cmd(`FSCR_OP_WRITE_LATCH_SET_CMD, 0, 32'h0, 0, 8'h00, 0);
        cmd(`FSCR_OP_CE, 0, 32'h0, 0, 8'h00, 0);
        wait_idle(1'b0);
        `CHK(kind_s, OP_CHIP)
    endtask
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        prot = 1'b0;
        done = 1'b0;
        done_cnt = 5'h00;
        err_total = 0;
        num_checks = 0;
        n_start = 0;
        wip_cyc = 0;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        repeat (3) @(negedge mclk);
        `CHK(status, 8'h00)
        `CHK(config_v, 8'h07)
        t_read(`FSCR_OP_RDST, 8'h00, 1'b0);
        t_no_latch();
        t_config();
        t_ops();
        t_protect();
        give_verdict();
    end
endmodule
